//--- hw/rak_bank.sv
// module: remote target alias bank, physical target map and receiver key readback over wishbone
// Functional notes
// [RULE1] alias slots 4-7 hold a 7-bit alias in bits 7-1, compared to target addresses
// [RULE2] a matching slot's transaction is forwarded with its paired physical address
// [RULE3] an alias of zero disables its slot; it never matches
// [RULE4] alias slots reset to zero, so every remote alias starts disabled
// [RULE5] key vector bytes 0-3 read-only at 80h-83h in byte order, reset zero
// [RULE6] bit 0 of each alias slot reads zero and ignores writes
// [RULE7] paired target-ID registers hold the 7-bit physical address in bits 7-1
// [RULE8] an address matching no enabled slot is not forwarded through any alias path
`timescale 1ns/1ps
module rak_bank
(
   input  wire logic                          clk,
   input  wire logic                          rst_b,
   // wishbone classic slave
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [rak_pkg::WB_ADR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [rak_pkg::WB_DAT_W-1:0]  wb_dat_i,
   output logic      [rak_pkg::WB_DAT_W-1:0]  wb_dat_o,
   output logic                               wb_ack_o,
   // key vector from the cipher engine
   input  wire logic                          key_load,
   input  wire logic [31:0]                   key_selection_vector,
   // target address seen by the local i2c controller
   input  wire logic                          i2c_addr_valid,
   input  wire logic [6:0]                    i2c_target_addr,
   // remapped request toward the control channel
   output logic                               fwd_valid,
   output logic [6:0]                         fwd_addr,
   output logic [1:0]                         fwd_slot,
   output logic                               nomatch
);
   import rak_pkg::*;

   // ======================================================================
   // storage
   logic [6:0] remote_alias_addr_4_ff;
   logic [6:0] remote_alias_addr_5_ff;
   logic [6:0] remote_alias_addr_6_ff;
   logic [6:0] remote_alias_addr_7_ff;
   logic [6:0] remote_physical_addr_4_ff;
   logic [6:0] remote_physical_addr_5_ff;
   logic [6:0] remote_physical_addr_6_ff;
   logic [6:0] remote_physical_addr_7_ff;
   logic [7:0] rx_key_vector_byte0_ff;
   logic [7:0] rx_key_vector_byte1_ff;
   logic [7:0] rx_key_vector_byte2_ff;
   logic [7:0] rx_key_vector_byte3_ff;
   logic       ack_ff;
   logic [31:0] rdat_ff;
   logic       fwd_valid_ff;
   logic [6:0] fwd_addr_ff;
   logic [1:0] fwd_slot_ff;
   logic       nomatch_ff;

   // ======================================================================
   // bus decode
   wire        bus_req   = wb_cyc_i && wb_stb_i && !ack_ff;
   wire        low_zero  = (wb_adr_i[1:0] == 2'b00);
   wire [7:0]  reg_idx   = wb_adr_i[9:2];
   wire        wr_lane0  = bus_req && wb_we_i && wb_sel_i[0] && low_zero;
   wire        sel_a4    = low_zero && (reg_idx == IDX_ALIAS_4);
   wire        sel_a5    = low_zero && (reg_idx == IDX_ALIAS_5);
   wire        sel_a6    = low_zero && (reg_idx == IDX_ALIAS_6);
   wire        sel_a7    = low_zero && (reg_idx == IDX_ALIAS_7);
   wire        sel_p4    = low_zero && (reg_idx == IDX_PHYS_4);
   wire        sel_p5    = low_zero && (reg_idx == IDX_PHYS_5);
   wire        sel_p6    = low_zero && (reg_idx == IDX_PHYS_6);
   wire        sel_p7    = low_zero && (reg_idx == IDX_PHYS_7);
   wire        sel_k0    = low_zero && (reg_idx == IDX_KEY_0);
   wire        sel_k1    = low_zero && (reg_idx == IDX_KEY_1);
   wire        sel_k2    = low_zero && (reg_idx == IDX_KEY_2);
   wire        sel_k3    = low_zero && (reg_idx == IDX_KEY_3);
   wire [6:0]  wr_field  = wb_dat_i[ADDR_FIELD_MSB:ADDR_FIELD_LSB];

   // ======================================================================
   // read multiplexer; bit 0 of address registers and upper bits read zero
   wire [7:0] rd_byte =
      sel_a4 ? {remote_alias_addr_4_ff, 1'b0} :             // [RULE6]
      sel_a5 ? {remote_alias_addr_5_ff, 1'b0} :
      sel_a6 ? {remote_alias_addr_6_ff, 1'b0} :
      sel_a7 ? {remote_alias_addr_7_ff, 1'b0} :
      sel_p4 ? {remote_physical_addr_4_ff, 1'b0} :
      sel_p5 ? {remote_physical_addr_5_ff, 1'b0} :
      sel_p6 ? {remote_physical_addr_6_ff, 1'b0} :
      sel_p7 ? {remote_physical_addr_7_ff, 1'b0} :
      sel_k0 ? rx_key_vector_byte0_ff :                      // [RULE5]
      sel_k1 ? rx_key_vector_byte1_ff :
      sel_k2 ? rx_key_vector_byte2_ff :
      sel_k3 ? rx_key_vector_byte3_ff :
      RD_UNMAPPED[7:0];
   wire [31:0] nxt_rdat = {24'h00_0000, rd_byte};

   // ======================================================================
   // bus answer: one registered ack per request, every address answered
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         ack_ff  <= 1'b0;
         rdat_ff <= RD_UNMAPPED;
      end
      else
      begin
         ack_ff  <= bus_req;
         rdat_ff <= bus_req ? nxt_rdat : RD_UNMAPPED;
      end
   end

   // ======================================================================
   // alias slots; only bits 7-1 are stored so bit 0 cannot be written
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         remote_alias_addr_4_ff <= ALIAS_RST; // [RULE4]
         remote_alias_addr_5_ff <= ALIAS_RST;
         remote_alias_addr_6_ff <= ALIAS_RST;
         remote_alias_addr_7_ff <= ALIAS_RST;
      end
      else
      begin
         if (wr_lane0 && sel_a4) remote_alias_addr_4_ff <= wr_field; // [RULE1]
         if (wr_lane0 && sel_a5) remote_alias_addr_5_ff <= wr_field;
         if (wr_lane0 && sel_a6) remote_alias_addr_6_ff <= wr_field;
         if (wr_lane0 && sel_a7) remote_alias_addr_7_ff <= wr_field;
      end
   end

   // ======================================================================
   // physical target addresses paired with the slots
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         remote_physical_addr_4_ff <= PHYS_RST;
         remote_physical_addr_5_ff <= PHYS_RST;
         remote_physical_addr_6_ff <= PHYS_RST;
         remote_physical_addr_7_ff <= PHYS_RST;
      end
      else
      begin
         if (wr_lane0 && sel_p4) remote_physical_addr_4_ff <= wr_field; // [RULE7]
         if (wr_lane0 && sel_p5) remote_physical_addr_5_ff <= wr_field;
         if (wr_lane0 && sel_p6) remote_physical_addr_6_ff <= wr_field;
         if (wr_lane0 && sel_p7) remote_physical_addr_7_ff <= wr_field;
      end
   end

   // ======================================================================
   // key bytes: loaded by the cipher engine only, bus writes are dropped
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         rx_key_vector_byte0_ff <= KEY_RST; // [RULE5]
         rx_key_vector_byte1_ff <= KEY_RST;
         rx_key_vector_byte2_ff <= KEY_RST;
         rx_key_vector_byte3_ff <= KEY_RST;
      end
      else if (key_load)
      begin
         rx_key_vector_byte0_ff <= key_selection_vector[7:0];
         rx_key_vector_byte1_ff <= key_selection_vector[15:8];
         rx_key_vector_byte2_ff <= key_selection_vector[23:16];
         rx_key_vector_byte3_ff <= key_selection_vector[31:24];
      end
   end

   // ======================================================================
   // alias decode and remap
   logic       m_hit;
   logic [1:0] m_slot;
   logic [6:0] m_addr;

   rak_alias_match
   #(
      .NUM_SLOTS (NUM_SLOTS)
   )
   u_match
   (
      .alias_vec   ({remote_alias_addr_7_ff, remote_alias_addr_6_ff,
                     remote_alias_addr_5_ff, remote_alias_addr_4_ff}),
      .phys_vec    ({remote_physical_addr_7_ff, remote_physical_addr_6_ff,
                     remote_physical_addr_5_ff, remote_physical_addr_4_ff}),
      .probe_addr  (i2c_target_addr),
      .hit         (m_hit),
      .slot        (m_slot),
      .mapped_addr (m_addr)
   );

   // a miss raises only nomatch, so the control channel sees nothing
   wire       nxt_fwd_valid = i2c_addr_valid && m_hit;  // [RULE8]
   wire       nxt_nomatch   = i2c_addr_valid && !m_hit; // [RULE8]
   wire [6:0] nxt_fwd_addr  = nxt_fwd_valid ? m_addr : fwd_addr_ff;
   wire [1:0] nxt_fwd_slot  = nxt_fwd_valid ? m_slot : fwd_slot_ff;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         fwd_valid_ff <= 1'b0;
         nomatch_ff   <= 1'b0;
         fwd_addr_ff  <= PHYS_RST;
         fwd_slot_ff  <= 2'h0;
      end
      else
      begin
         fwd_valid_ff <= nxt_fwd_valid;
         nomatch_ff   <= nxt_nomatch;
         fwd_addr_ff  <= nxt_fwd_addr; // [RULE2]
         fwd_slot_ff  <= nxt_fwd_slot;
      end
   end

   assign wb_ack_o  = ack_ff;
   assign wb_dat_o  = rdat_ff;
   assign fwd_valid = fwd_valid_ff;
   assign fwd_addr  = fwd_addr_ff;
   assign fwd_slot  = fwd_slot_ff;
   assign nomatch   = nomatch_ff;

   // ======================================================================
   // checks
   logic [6:0] chk_alias_sel;
   logic [6:0] chk_phys_sel;
   always_comb
   begin
      unique case (fwd_slot_ff)
         2'h0:
         begin
            chk_alias_sel = remote_alias_addr_4_ff;
            chk_phys_sel  = remote_physical_addr_4_ff;
         end
         2'h1:
         begin
            chk_alias_sel = remote_alias_addr_5_ff;
            chk_phys_sel  = remote_physical_addr_5_ff;
         end
         2'h2:
         begin
            chk_alias_sel = remote_alias_addr_6_ff;
            chk_phys_sel  = remote_physical_addr_6_ff;
         end
         2'h3:
         begin
            chk_alias_sel = remote_alias_addr_7_ff;
            chk_phys_sel  = remote_physical_addr_7_ff;
         end
      endcase
   end

   chk_ack_one_cycle: assert property (@(posedge clk) disable iff (!rst_b)
      (wb_cyc_i && wb_stb_i && !ack_ff) |=> ack_ff ##1 !ack_ff)
      else $error("bus ack not a single cycle after request");

   chk_alias_reset_zero: assert property (@(posedge clk) // [RULE4]
      $rose(rst_b) |-> (remote_alias_addr_4_ff == 7'h00) && (remote_alias_addr_5_ff == 7'h00) &&
                       (remote_alias_addr_6_ff == 7'h00) && (remote_alias_addr_7_ff == 7'h00))
      else $error("alias slots not zero after reset");

   chk_alias_bit0_zero: assert property (@(posedge clk) disable iff (!rst_b) // [RULE6]
      (bus_req && !wb_we_i && (sel_a4 || sel_a5 || sel_a6 || sel_a7)) |=> (rdat_ff[0] == 1'b0))
      else $error("alias slot bit 0 read nonzero");

   chk_alias_write_takes: assert property (@(posedge clk) disable iff (!rst_b) // [RULE1]
      (wr_lane0 && sel_a5) |=> (remote_alias_addr_5_ff == $past(wb_dat_i[7:1])))
      else $error("alias slot write not stored from bits 7-1");

   chk_key_read_order: assert property (@(posedge clk) disable iff (!rst_b) // [RULE5]
      (bus_req && !wb_we_i && sel_k2 && !key_load) |=> (rdat_ff == {24'h00_0000, rx_key_vector_byte2_ff}))
      else $error("key byte 2 read wrong data");

   chk_key_readonly: assert property (@(posedge clk) disable iff (!rst_b) // [RULE5]
      (wr_lane0 && sel_k0 && !key_load) |=> $stable(rx_key_vector_byte0_ff))
      else $error("key byte changed by a bus write");

   chk_remap_physical: assert property (@(posedge clk) disable iff (!rst_b) // [RULE2] [RULE7]
      (i2c_addr_valid && m_hit) ##1 $stable(chk_phys_sel) |-> fwd_valid_ff && (fwd_addr_ff == chk_phys_sel))
      else $error("forwarded address is not the paired physical address");

   chk_remap_alias_match: assert property (@(posedge clk) disable iff (!rst_b) // [RULE1]
      fwd_valid_ff && $stable(chk_alias_sel) |-> ($past(i2c_target_addr) == chk_alias_sel))
      else $error("forwarded through a slot whose alias does not match");

   chk_zero_alias_off: assert property (@(posedge clk) disable iff (!rst_b) // [RULE3]
      fwd_valid_ff |-> (chk_alias_sel != 7'h00) || !$stable(chk_alias_sel))
      else $error("forwarded through a disabled slot");

   chk_miss_no_forward: assert property (@(posedge clk) disable iff (!rst_b) // [RULE8]
      (i2c_addr_valid && !m_hit) |=> !fwd_valid_ff && nomatch_ff)
      else $error("unmatched address forwarded");

endmodule

//--- hw/rak_pkg.sv
// package: register map, field layout and reset values of the alias and key readback bank
package rak_pkg;

   // ======================================================================
   // bus geometry
   localparam int WB_ADR_W  = 10;
   localparam int WB_DAT_W  = 32;
   localparam int REG_W     = 8;
   localparam int ADDR7_W   = 7;
   localparam int NUM_SLOTS = 4;
   localparam int SLOT_W    = 2;
   localparam int KEY_BYTES = 4;

   // ======================================================================
   // register indices; byte address on the bus is four times the index
   localparam logic [7:0] IDX_PHYS_4  = 8'h73;
   localparam logic [7:0] IDX_PHYS_5  = 8'h74;
   localparam logic [7:0] IDX_PHYS_6  = 8'h75;
   localparam logic [7:0] IDX_PHYS_7  = 8'h76;
   localparam logic [7:0] IDX_ALIAS_4 = 8'h7A;
   localparam logic [7:0] IDX_ALIAS_5 = 8'h7B;
   localparam logic [7:0] IDX_ALIAS_6 = 8'h7C;
   localparam logic [7:0] IDX_ALIAS_7 = 8'h7D;
   localparam logic [7:0] IDX_KEY_0   = 8'h80;
   localparam logic [7:0] IDX_KEY_1   = 8'h81;
   localparam logic [7:0] IDX_KEY_2   = 8'h82;
   localparam logic [7:0] IDX_KEY_3   = 8'h83;

   // ======================================================================
   // field layout and reset values
   localparam int          ADDR_FIELD_LSB = 1;
   localparam int          ADDR_FIELD_MSB = 7;
   localparam int          RSVD_BIT       = 0;
   localparam logic [6:0]  ALIAS_OFF      = 7'h00;
   localparam logic [6:0]  ALIAS_RST      = 7'h00;
   localparam logic [6:0]  PHYS_RST       = 7'h00;
   localparam logic [7:0]  KEY_RST        = 8'h00;
   localparam logic [31:0] RD_UNMAPPED    = 32'h0000_0000;

endpackage

//--- hw/rak_alias_match.sv
// module: per-slot alias compare and priority remap to the physical target address
`timescale 1ns/1ps
module rak_alias_match
#(
   parameter int NUM_SLOTS = 4
)
(
   input  wire logic [NUM_SLOTS*7-1:0] alias_vec,
   input  wire logic [NUM_SLOTS*7-1:0] phys_vec,
   input  wire logic [6:0]             probe_addr,
   output logic                        hit,
   output logic [1:0]                  slot,
   output logic [6:0]                  mapped_addr
);
   import rak_pkg::*;

   logic [NUM_SLOTS-1:0] slot_hit;

   // ======================================================================
   // compare per slot; an all-zero alias never matches
   genvar g;
   generate
      for (g = 0; g < NUM_SLOTS; g++)
      begin : g_slot
         assign slot_hit[g] = (alias_vec[g*7 +: 7] != ALIAS_OFF) &&
                              (alias_vec[g*7 +: 7] == probe_addr); // [RULE1] [RULE3]
      end
   endgenerate

   // ======================================================================
   // lowest slot wins when software programs the same alias twice
   always_comb
   begin
      hit         = 1'b0;
      slot        = 2'h0;
      mapped_addr = 7'h00;
      for (int i = NUM_SLOTS - 1; i >= 0; i--)
      begin
         if (slot_hit[i])
         begin
            hit         = 1'b1;
            slot        = i[1:0];
            mapped_addr = phys_vec[i*7 +: 7]; // [RULE2]
         end
      end
   end

endmodule

//--- test/rak_i2c_host_model.sv
// partner model: local i2c host presenting target addresses to the alias decoder
`timescale 1ns/1ps
module rak_i2c_host_model
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       send,
   input  wire logic [6:0] send_addr,
   output logic            i2c_addr_valid,
   output logic [6:0]      i2c_target_addr
);
   logic [6:0] last_addr_ff;
   // ======================================================================
   // idle lines show the inverse of the last address so a stale value never looks fresh
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         last_addr_ff <= 7'h00;
      else if (send)
         last_addr_ff <= send_addr;
   end
   assign i2c_addr_valid  = send & rst_b;
   assign i2c_target_addr = send ? send_addr : ~last_addr_ff;
endmodule

//--- test/rak_bank_tb_top.sv
// testbench: alias remap, reserved bits and key readback of the register bank
`timescale 1ns/1ps
module rak_bank_tb_top;
   import rak_pkg::*;
   // ======================================================================
   // stimulus and observed signals
   logic        clk        = 1'b0;
   logic        rst_b      = 1'b0;
   logic        wb_cyc_i   = 1'b0;
   logic        wb_stb_i   = 1'b0;
   logic        wb_we_i    = 1'b0;
   logic [9:0]  wb_adr_i   = 10'h000;
   logic [3:0]  wb_sel_i   = 4'h0;
   logic [31:0] wb_dat_i   = 32'h0;
   logic        key_load   = 1'b0;
   logic [31:0] key_vec    = 32'h0;
   logic        send       = 1'b0;
   logic [6:0]  send_addr  = 7'h00;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        i2c_addr_valid;
   logic [6:0]  i2c_target_addr;
   logic        fwd_valid;
   logic [6:0]  fwd_addr;
   logic [1:0]  fwd_slot;
   logic        nomatch;
   logic [6:0]  alias_m [4] = '{default: 7'h00};
   logic [6:0]  phys_m [4]  = '{default: 7'h00};
   int          mismatches  = 0;
   int          check_count = 0;

   always #20 clk = ~clk;

   rak_i2c_host_model i_rak_i2c_host_model (.clk(clk), .rst_b(rst_b), .send(send), .send_addr(send_addr),
      .i2c_addr_valid(i2c_addr_valid), .i2c_target_addr(i2c_target_addr));
   rak_bank i_rak_bank (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .key_load(key_load), .key_selection_vector(key_vec), .i2c_addr_valid(i2c_addr_valid),
      .i2c_target_addr(i2c_target_addr), .fwd_valid(fwd_valid), .fwd_addr(fwd_addr), .fwd_slot(fwd_slot),
      .nomatch(nomatch));

   // ======================================================================
   // reporting
   task automatic end_sim();
      if (mismatches == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         mismatches++;
      end
   endtask

   task automatic chk_bit(input string name, input logic exp, input logic got);
      chk_word(name, {31'h0, exp}, {31'h0, got});
   endtask

   // ======================================================================
   // bus cycles; released lines are inverted so stale data never reads as valid
   task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= 4'hF;
      wb_dat_i <= wd;
      @(posedge clk);
      while (wb_ack_o !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 20)
      begin
         chk_bit("wb_ack_o", 1'b1, wb_ack_o);
         end_sim();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= ~we;
      wb_adr_i <= ~{idx, 2'b00};
      wb_dat_i <= ~wd;
      @(posedge clk);
      chk_bit("wb_ack_o low", 1'b0, wb_ack_o);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
      logic [31:0] d;
      wb_xfer(1'b1, idx, wd, d);
   endtask

   task automatic rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      wb_xfer(1'b0, idx, 32'h0, d);
      chk_word(name, exp, d);
   endtask

   // ======================================================================
   // remap expectation: lowest enabled slot holding the address wins
   function automatic logic [2:0] exp_hit(input logic [6:0] a);
      logic [2:0] r;
      r = 3'b000;
      for (int k = 3; k >= 0; k--)
         if (alias_m[k] != 7'h00 && alias_m[k] == a)
            r = {1'b1, k[1:0]};
      return r;
   endfunction

   task automatic probe(input logic [6:0] a);
      logic [2:0] e;
      e = exp_hit(a);
      send      <= 1'b1;
      send_addr <= a;
      @(posedge clk);
      send <= 1'b0;
      @(posedge clk);
      chk_bit("fwd_valid", e[2], fwd_valid);
      chk_bit("nomatch", ~e[2], nomatch);
      if (e[2])
      begin
         chk_word("fwd_addr", {25'h0, phys_m[e[1:0]]}, {25'h0, fwd_addr});
         chk_word("fwd_slot", {30'h0, e[1:0]}, {30'h0, fwd_slot});
      end
   endtask

   // ======================================================================
   // main sequence
   initial
   begin
      logic [31:0] r;
      r = $urandom(32'h4FEEE639);
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 4; i++)
      begin
         rd_chk("alias reset", IDX_ALIAS_4 + i[7:0], 32'h0);
         rd_chk("phys reset", IDX_PHYS_4 + i[7:0], 32'h0);
         rd_chk("key reset", IDX_KEY_0 + i[7:0], 32'h0);
      end
      probe(7'h00);
      probe(7'($urandom));
      for (int i = 0; i < 4; i++)
      begin
         phys_m[i]  = 7'($urandom);
         alias_m[i] = (i == 2) ? alias_m[1] : 7'($urandom_range(127, 1));
         r          = $urandom;
         wr(IDX_PHYS_4 + i[7:0], {24'h0, phys_m[i], 1'b1});
         wr(IDX_ALIAS_4 + i[7:0], {r[23:0], alias_m[i], 1'b1});
         rd_chk("alias bit0", IDX_ALIAS_4 + i[7:0], {24'h0, alias_m[i], 1'b0});
         rd_chk("phys value", IDX_PHYS_4 + i[7:0], {24'h0, phys_m[i], 1'b0});
      end
      for (int i = 0; i < 4; i++)
         probe(alias_m[i]);
      for (int i = 0; i < 24; i++)
         probe(7'($urandom));
      wr(IDX_ALIAS_5, 32'h0000_0001);
      alias_m[1] = 7'h00;
      probe(alias_m[2]);
      probe(7'h00);
      wr(IDX_KEY_0, 32'h0000_00FF);
      rd_chk("key write", IDX_KEY_0, 32'h0);
      wr(8'h7E, 32'h0000_00FF);
      rd_chk("unmapped", 8'h7E, 32'h0);
      key_vec  <= $urandom;
      key_load <= 1'b1;
      @(posedge clk);
      key_load <= 1'b0;
      for (int i = 0; i < 4; i++)
         rd_chk("key byte", IDX_KEY_0 + i[7:0], {24'h0, key_vec[8*i +: 8]});
      end_sim();
   end
endmodule
